// >>> pfm_top.sv
// Pin function multiplexer and pad control for the six-line port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Power-on into user mode: line 5 port input.
// - Reset pin enable makes line 5 reset input.
// - Reset function sticks until next power-on.
// - Reset pin enable forces line 5 pullup.
// - Power-on into background: line 5 is reset.
// - Timer 2 capture takes line 5 level.
// - Line 4 selects mode in reset, then debug.
// - Every reset sets debug pin enable.
// - Debug pin enable forces line 4 pullup.
// - Sample mode select at reset release.
// - Debug controller drives line 4 through dbg_oe and dbg_out.
// - Debug pin pseudo open-drain with speedup pulses.
// - External reset alone never selects background.
// - Reset floats lines 0 to 3; line 4 pulled up, line 5 only with reset pin.
// - Line 4 resets slew on; all lines reset low drive.
// - Each line has its own pullup enable.
// - Driven lines lose their pullup, except line 4 while debug pin enabled.
// - Analog-owned lines lose their pullup.
// - Rising edge selection turns pull into pulldown.
// - Per-line slew enable, ignored on inputs.
// - Per-line drive select, set means high.
// - Fixed ownership priority per line.
// - Both analog modules share a pin together.
module pfm_top (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic POR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [5:0] PAD_IN,
  output pfm_pkg::pfm_pad_t [5:0] PAD_CTL,
  input wire pfm_pkg::pfm_req_t PERIPH_REQ,
  output pfm_pkg::pfm_route_t PERIPH_ROUTE,
  output logic EXT_RESET_REQ,
  output logic FORCE_RESET_REQ,
  output logic BACKGROUND_MODE
);
  import pfm_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Resolves the pull device of a line: returns pullup, pulldown.
  function automatic logic [1:0] pull_of(input logic enable,
                                         input logic driven,
                                         input logic analog,
                                         input logic rising);
    logic on;
    on = enable & ~driven & ~analog;
    pull_of = {on & ~rising, on & rising};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic reset_pin_enable;  // Line 5 is the reset input.
  logic debug_pin_enable;  // Line 4 is the debug pin.
  logic [5:0] pin_pullup_enable;  // Pullup request per line.
  logic [5:0] pin_slew_limit_enable;  // Slew limit per line.
  logic [5:0] pin_high_drive_select;  // High drive per line.
  logic reset_q;  // Reset level one cycle ago.
  logic por_cause;  // The reset in progress came from power-on.
  logic force_cause;  // The reset in progress was debug forced.
  logic sample;  // First cycle after the reset release.
  logic next_bg;  // Mode decided by the mode-select level.
  logic bus_access;  // Access phase waiting for the answer.
  logic bus_fire;  // Transfer completes at this edge.
  logic wr_fire;  // Write takes effect at this edge.
  logic [31:0] rd_data;  // Read data for the addressed register.
  logic rd_err;  // Address maps to no register.
  pfm_pad_t [5:0] next_pad;  // Pad controls for the next cycle.
  pfm_route_t next_route;  // Routed levels for the next cycle.
  logic next_ext_reset;  // External reset request for next cycle.

  assign sample = reset_q & ~RESET;
  assign next_bg = (por_cause | force_cause) & ~PAD_IN[LINE_DEBUG];
  assign bus_access = PSEL & PENABLE & ~RESET;
  assign bus_fire = bus_access & PREADY;
  assign wr_fire = bus_fire & PWRITE;

  // ----------------------------------------------------------------------
  // Reset tracking and mode selection
  // ----------------------------------------------------------------------
  // Delays the reset level so that its release can be seen.
  always_ff @(posedge MCLK) begin
    reset_q <= RESET;
  end

  // Remembers a power-on until the reset it caused is released.
  always_ff @(posedge MCLK) begin
    if (POR) begin
      por_cause <= 1'b1;
    end else if (sample) begin
      por_cause <= 1'b0;
    end
  end

  // Remembers a debug forced reset until the next reset release or power-on.
  always_ff @(posedge MCLK) begin
    if (POR) begin
      force_cause <= 1'b0;
    end else if (wr_fire && PADDR == ADDR_FORCE && PWDATA[BIT_FORCE_DBG]) begin
      force_cause <= 1'b1;
    end else if (sample) begin
      force_cause <= 1'b0;
    end
  end

  // Samples the mode-select level in the first cycle after reset release.
  always_ff @(posedge MCLK) begin
    if (POR) begin
      BACKGROUND_MODE <= 1'b0;
    end else if (sample) begin
      BACKGROUND_MODE <= next_bg;
    end
  end

  // Issues a one-cycle reset request when software forces a debug reset.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      FORCE_RESET_REQ <= 1'b0;
    end else begin
      FORCE_RESET_REQ <= wr_fire && PADDR == ADDR_FORCE &&
                         PWDATA[BIT_FORCE_DBG];
    end
  end

  // ----------------------------------------------------------------------
  // Option and pin-control registers
  // ----------------------------------------------------------------------
  // Reset pin enable clears only at power-on and can only be set.
  always_ff @(posedge MCLK) begin
    if (POR) begin
      reset_pin_enable <= 1'b0;
    end else if (sample && next_bg) begin
      reset_pin_enable <= 1'b1;
    end else if (wr_fire && PADDR == ADDR_OPTION &&
                 PWDATA[BIT_RST_PIN_EN]) begin
      reset_pin_enable <= 1'b1;
    end
  end

  // Debug pin enable is set by every reset, software may clear it.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      debug_pin_enable <= 1'b1;
    end else if (wr_fire && PADDR == ADDR_OPTION) begin
      debug_pin_enable <= PWDATA[BIT_DBG_PIN_EN];
    end
  end

  // Per-line pad control bits, independent of the port registers.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      pin_pullup_enable <= PULLUP_RESET;
      pin_slew_limit_enable <= SLEW_RESET;
      pin_high_drive_select <= DRIVE_RESET;
    end else if (wr_fire) begin
      if (PADDR == ADDR_PULLUP) begin
        pin_pullup_enable <= PWDATA[5:0];
      end
      if (PADDR == ADDR_SLEW) begin
        pin_slew_limit_enable <= PWDATA[5:0];
      end
      if (PADDR == ADDR_DRIVE) begin
        pin_high_drive_select <= PWDATA[5:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Selects read data and flags addresses that hold no register.
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (PADDR)
      ADDR_OPTION: begin
        rd_data[BIT_RST_PIN_EN] = reset_pin_enable;
        rd_data[BIT_DBG_PIN_EN] = debug_pin_enable;
      end
      ADDR_PULLUP: rd_data[5:0] = pin_pullup_enable;
      ADDR_SLEW: rd_data[5:0] = pin_slew_limit_enable;
      ADDR_DRIVE: rd_data[5:0] = pin_high_drive_select;
      ADDR_FORCE: rd_data = 32'h0000_0000;  // Force bit reads as zero.
      ADDR_STATUS: begin
        rd_data[STAT_BG_MODE] = BACKGROUND_MODE;
        rd_data[STAT_RST_PIN] = reset_pin_enable;
        rd_data[STAT_DBG_PIN] = debug_pin_enable;
        for (int i = 0; i < PIN_COUNT; i++) begin
          rd_data[STAT_OE_LSB + i] = PAD_CTL[i].oe;
        end
      end
      default: rd_err = 1'b1;  // Unmapped or unaligned address.
    endcase
  end

  // Answers every access outside reset after one wait state with data and error.
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= bus_access & ~PREADY;
      if (bus_access && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_data;
        PSLVERR <= rd_err;
      end else begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin ownership and pad control
  // ----------------------------------------------------------------------
  // Resolves the owner of each line, lowest to highest priority; line 5 is resolved highest first.
  always_comb begin
    logic analog;
    logic [1:0] pull;
    analog = 1'b0;
    pull = 2'b00;
    next_ext_reset = 1'b0;
    next_route = '0;
    next_route.gpio_in = PAD_IN;
    next_route.keypad_in = 4'hf;
    next_route.irq_in = 1'b1;
    next_route.dbg_in = PAD_IN[LINE_DEBUG];
    // Lines 0 to 3: port, keypad, timer 1 or clock, analog.
    for (int i = 0; i < KEY_COUNT; i++) begin
      analog = PERIPH_REQ.ana_a[i] | PERIPH_REQ.ana_b[i];
      next_pad[i].oe = PERIPH_REQ.gpio_dir[i];
      next_pad[i].out = PERIPH_REQ.gpio_out[i];
      if (i < 2 && PERIPH_REQ.t1_oe[i[0]]) begin
        next_pad[i].oe = 1'b1;
        next_pad[i].out = PERIPH_REQ.t1_out[i[0]];
      end
      if (i >= 2 && PERIPH_REQ.tclk_en[i[0]]) begin
        next_pad[i].oe = 1'b0;  // Timer clock is an input.
      end
      if (analog) begin
        next_pad[i].oe = 1'b0;
      end
      pull = pull_of(pin_pullup_enable[i], next_pad[i].oe, analog,
                     PERIPH_REQ.kbi_en[i] & PERIPH_REQ.kbi_rise[i]);
      next_pad[i].pu = pull[1];
      next_pad[i].pd = pull[0];
      if (PERIPH_REQ.kbi_en[i] && !analog) begin
        next_route.keypad_in[i] = PAD_IN[i];
      end
      next_route.ana_a_sel[i] = PERIPH_REQ.ana_a[i];
      next_route.ana_b_sel[i] = PERIPH_REQ.ana_b[i];
    end
    next_route.t1_in = PAD_IN[1:0];
    next_route.tclk_in = PAD_IN[3:2];
    // Line 4: port, timer 2 output, debug.
    next_pad[LINE_DEBUG].oe = PERIPH_REQ.gpio_dir[LINE_DEBUG];
    next_pad[LINE_DEBUG].out = PERIPH_REQ.gpio_out[LINE_DEBUG];
    if (PERIPH_REQ.t2_oe) begin
      next_pad[LINE_DEBUG].oe = 1'b1;
      next_pad[LINE_DEBUG].out = PERIPH_REQ.t2_out;
    end
    if (debug_pin_enable) begin
      // The controller drives low and brief high speedup pulses.
      next_pad[LINE_DEBUG].oe = PERIPH_REQ.dbg_oe;
      next_pad[LINE_DEBUG].out = PERIPH_REQ.dbg_out;
    end
    pull = pull_of(pin_pullup_enable[LINE_DEBUG], next_pad[LINE_DEBUG].oe,
                   1'b0, 1'b0);
    next_pad[LINE_DEBUG].pu = pull[1] | debug_pin_enable;
    next_pad[LINE_DEBUG].pd = 1'b0;
    // Line 5: input only; port, timer 2 capture, interrupt, reset.
    next_pad[LINE_RESET].oe = 1'b0;
    next_pad[LINE_RESET].out = 1'b0;
    pull = pull_of(pin_pullup_enable[LINE_RESET], 1'b0, 1'b0,
                   PERIPH_REQ.irq_en & PERIPH_REQ.irq_rise);
    next_pad[LINE_RESET].pu = pull[1];
    next_pad[LINE_RESET].pd = pull[0];
    if (reset_pin_enable) begin
      next_pad[LINE_RESET].pu = 1'b1;
      next_pad[LINE_RESET].pd = 1'b0;
      next_ext_reset = ~PAD_IN[LINE_RESET];
    end else if (PERIPH_REQ.irq_en) begin
      next_route.irq_in = PAD_IN[LINE_RESET];
    end else if (PERIPH_REQ.t2_capture) begin
      next_route.t2_capture_in = PAD_IN[LINE_RESET];
    end
    // Slew and drive apply to every line; inert while not driving.
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_pad[i].slew = pin_slew_limit_enable[i];
      next_pad[i].hdrv = pin_high_drive_select[i];
    end
    // In reset no line drives; line 4 pulled up as mode-select input, line 5 per reset pin.
    if (RESET) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        next_pad[i].oe = 1'b0;
        next_pad[i].out = 1'b0;
        next_pad[i].pd = 1'b0;
        next_pad[i].pu = 1'b0;
        next_pad[i].slew = SLEW_RESET[i];
        next_pad[i].hdrv = DRIVE_RESET[i];
      end
      next_pad[LINE_DEBUG].pu = 1'b1;
      next_pad[LINE_RESET].pu = reset_pin_enable;
      next_ext_reset = reset_pin_enable & ~PAD_IN[LINE_RESET];
    end
  end

  // Registers every pad control and routed level.
  always_ff @(posedge MCLK) begin
    PAD_CTL <= next_pad;
    PERIPH_ROUTE <= next_route;
    EXT_RESET_REQ <= next_ext_reset;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_user_por;
    @(posedge MCLK) disable iff (POR)
      (sample && por_cause && PAD_IN[LINE_DEBUG]) |=> !reset_pin_enable;
  endproperty
  a_user_por: assert property (p_user_por) else $error("por pin set");

  property p_ext_reset;
    @(posedge MCLK) disable iff (POR)
      (reset_pin_enable && !PAD_IN[LINE_RESET]) |=> EXT_RESET_REQ;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("no reset req");

  property p_reset_sticky;
    @(posedge MCLK) disable iff (POR)
      reset_pin_enable |=> reset_pin_enable [*2];
  endproperty
  a_reset_sticky: assert property (p_reset_sticky) else $error("lost");

  property p_reset_pullup;
    @(posedge MCLK) disable iff (POR)
      reset_pin_enable |=> PAD_CTL[LINE_RESET].pu;
  endproperty
  a_reset_pullup: assert property (p_reset_pullup) else $error("no pu");

  property p_debug_set;
    @(posedge MCLK) RESET ##1 !RESET |-> debug_pin_enable;
  endproperty
  a_debug_set: assert property (p_debug_set) else $error("dbg not set");

  property p_debug_pullup;
    @(posedge MCLK) debug_pin_enable |=> PAD_CTL[LINE_DEBUG].pu;
  endproperty
  a_debug_pullup: assert property (p_debug_pullup) else $error("no pu4");

  property p_ext_no_bg;
    @(posedge MCLK) disable iff (POR)
      (sample && !por_cause && !force_cause) |=> !BACKGROUND_MODE;
  endproperty
  a_ext_no_bg: assert property (p_ext_no_bg) else $error("bg by reset");

  property p_driven_no_pull;
    @(posedge MCLK) disable iff (RESET)
      PAD_CTL[0].oe |-> !PAD_CTL[0].pu && !PAD_CTL[0].pd;
  endproperty
  a_driven_no_pull: assert property (p_driven_no_pull)
    else $error("pu on");

  property p_analog_free;
    @(posedge MCLK) disable iff (RESET)
      (PERIPH_REQ.ana_a[1] || PERIPH_REQ.ana_b[1]) |=>
        !PAD_CTL[1].oe && !PAD_CTL[1].pu;
  endproperty
  a_analog_free: assert property (p_analog_free) else $error("ana pu");

endmodule

`default_nettype wire

// >>> pfm_pkg.sv
// Package of constants and carrier types for the pin function multiplexer.
package pfm_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int PIN_COUNT = 6;  // Port lines 0 to 5.
  localparam int KEY_COUNT = 4;  // Lines 0 to 3 carry keypad and analog.
  localparam int LINE_DEBUG = 4;  // Debug and mode-select line.
  localparam int LINE_RESET = 5;  // Input-only reset and interrupt line.

  // ----------------------------------------------------------------------
  // APB register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_OPTION = 8'h00;  // System option register 1.
  localparam logic [7:0] ADDR_PULLUP = 8'h04;  // Pin pullup enables.
  localparam logic [7:0] ADDR_SLEW = 8'h08;  // Pin slew limit enables.
  localparam logic [7:0] ADDR_DRIVE = 8'h0c;  // Pin high drive selects.
  localparam logic [7:0] ADDR_FORCE = 8'h10;  // Debug force reset register.
  localparam logic [7:0] ADDR_STATUS = 8'h14;  // Read-only block state.

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_RST_PIN_EN = 0;  // Reset pin enable in option reg.
  localparam int BIT_DBG_PIN_EN = 1;  // Debug pin enable in option reg.
  localparam int BIT_FORCE_DBG = 0;  // Force debug reset bit.
  localparam int STAT_BG_MODE = 0;  // Background mode was selected.
  localparam int STAT_RST_PIN = 1;  // Reset pin enable copy.
  localparam int STAT_DBG_PIN = 2;  // Debug pin enable copy.
  localparam int STAT_OE_LSB = 8;  // Live output enables, six bits.

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [5:0] PULLUP_RESET = 6'h00;  // All pullups off.
  localparam logic [5:0] SLEW_RESET = 6'h10;  // Line 4 slew on.
  localparam logic [5:0] DRIVE_RESET = 6'h00;  // All lines low drive.

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  // Control of one pad cell.
  typedef struct packed {
    logic oe;    // Output buffer enable.
    logic out;   // Output level.
    logic pu;    // Internal pullup on.
    logic pd;    // Internal pulldown on.
    logic slew;  // Slew rate limiting on.
    logic hdrv;  // High drive strength.
  } pfm_pad_t;

  // Requests from port logic and peripherals.
  typedef struct packed {
    logic [5:0] gpio_dir;  // Port direction, 1 is output.
    logic [5:0] gpio_out;  // Port output data.
    logic [3:0] kbi_en;  // Keypad input enables.
    logic [3:0] kbi_rise;  // Keypad rising edge selects.
    logic [1:0] t1_oe;  // Timer 1 channel output enables.
    logic [1:0] t1_out;  // Timer 1 channel output levels.
    logic [1:0] tclk_en;  // Timer external clock enables.
    logic [3:0] ana_a;  // First analog module channel enables.
    logic [3:0] ana_b;  // Second analog module channel enables.
    logic t2_oe;  // Timer 2 channel 0 output enable.
    logic t2_out;  // Timer 2 channel 0 output level.
    logic t2_capture;  // Timer 2 channel 0 in input capture.
    logic irq_en;  // Interrupt request pin enable.
    logic irq_rise;  // Interrupt request rising edge select.
    logic dbg_oe;  // Debug controller drives the debug pin.
    logic dbg_out;  // Debug controller drive level.
  } pfm_req_t;

  // Pin levels routed to peripherals.
  typedef struct packed {
    logic [5:0] gpio_in;  // Port input data.
    logic [3:0] keypad_in;  // Keypad inputs, idle high.
    logic [1:0] t1_in;  // Timer 1 channel inputs.
    logic [1:0] tclk_in;  // Timer external clocks.
    logic [3:0] ana_a_sel;  // Analog pin access, first module.
    logic [3:0] ana_b_sel;  // Analog pin access, second module.
    logic t2_capture_in;  // Timer 2 channel 0 capture input.
    logic irq_in;  // Interrupt request level, idle high.
    logic dbg_in;  // Debug pin level.
  } pfm_route_t;

endpackage

// >>> pfm_board.sv
// Board and debug pod model that turns pad controls into pin levels.
`timescale 1ns/1ps
`default_nettype none
module pfm_board (
  input wire logic clk,
  input wire pfm_pkg::pfm_pad_t [5:0] ctl,
  input wire logic [5:0] hold_en,
  input wire logic [5:0] hold_val,
  output logic [5:0] level
);
  import pfm_pkg::*;
  logic wobble = 1'b0;  // Changes every cycle for undriven pins.

  // ----------------------------------------------------------------------
  // Floating pattern
  // ----------------------------------------------------------------------
  // A floating pin must never settle on a friendly value.
  always_ff @(posedge clk) begin
    wobble <= ~wobble;
  end

  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  // Pad driver first, then the pod or source, then the pull device.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (ctl[i].oe) begin
        level[i] = ctl[i].out;
      end else if (hold_en[i]) begin
        level[i] = hold_val[i];
      end else if (ctl[i].pu) begin
        level[i] = 1'b1;
      end else if (ctl[i].pd) begin
        level[i] = 1'b0;
      end else begin
        level[i] = wobble ^ i[0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> pfm_tb.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pfm_pkg::*;
  logic mclk = 1'b0;  // Bus clock, 25 ns period.
  logic rst = 1'b1;  // Any reset.
  logic por = 1'b1;  // Power-on reset.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] pad_in;
  pfm_pad_t [5:0] pad_ctl;
  pfm_req_t req = '0;  // Peripheral requests.
  pfm_route_t route;
  logic ext_rst;
  logic frc_rst;
  logic bg_mode;
  logic [5:0] hold_en = 6'h00;  // Pod or source drives a pin.
  logic [5:0] hold_val = 6'h00;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd;  // Last read data.
  logic err;  // Last error response.
  logic [5:0] pe;
  logic [5:0] s;
  logic seen;

  always #12.5 mclk = ~mclk;

  pfm_top pfm_top_i (.MCLK(mclk), .RESET(rst), .POR(por), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_in),
    .PAD_CTL(pad_ctl), .PERIPH_REQ(req), .PERIPH_ROUTE(route),
    .EXT_RESET_REQ(ext_rst), .FORCE_RESET_REQ(frc_rst),
    .BACKGROUND_MODE(bg_mode));
  pfm_board pfm_board_i (.clk(mclk), .ctl(pad_ctl), .hold_en(hold_en),
    .hold_val(hold_val), .level(pad_in));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; waits for the answer under a bounded count.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      finish_test();
    end
  endtask

  // Reset of either kind, with the pod holding line 4 low if asked.
  task automatic do_reset(input logic p, input logic low4);
    rst <= 1'b1;
    por <= p;
    hold_en[4] <= low4;
    hold_val[4] <= 1'b0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    repeat (3) @(posedge mclk);
    hold_en[4] <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------------
  // Gathers one pad field of all six lines.
  function automatic logic [31:0] fld(input int k);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) begin
      v[i] = k == 0 ? pad_ctl[i].oe : k == 1 ? pad_ctl[i].pu :
             k == 2 ? pad_ctl[i].pd : pad_ctl[i].slew;
    end
    return v;
  endfunction

  // Pullups: enabled bits minus driven or analog lines; debug forces 4.
  function automatic logic [31:0] exp_pu(input logic [5:0] en,
                                         input logic [3:0] off);
    logic [31:0] v;
    v = {26'h0, en & ~{2'b00, off}};
    v[4] = 1'b1;
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h0ec6));
    do_reset(1'b1, 1'b0);
    chk("bg", 0, 32'(bg_mode));
    chk("pu", 32'h10, fld(1));
    chk("oe", 0, fld(0));
    apb(0, ADDR_OPTION, 0);
    chk("opt", 32'h2, rd);
    apb(0, ADDR_SLEW, 0);
    chk("slew", 32'(SLEW_RESET), rd);
    apb(0, ADDR_DRIVE, 0);
    chk("drive", 0, rd);
    // Random pullups against random outputs and analog owners.
    for (int t = 0; t < 4; t++) begin
      pe = 6'($urandom());
      s = 6'($urandom());
      req.gpio_dir <= {2'b00, s[3:0]};
      req.ana_a <= {s[5:4], 2'b00};
      apb(1, ADDR_PULLUP, {26'h0, pe});
      repeat (3) @(posedge mclk);
      chk("pu", exp_pu(pe, s[3:0] | {s[5:4], 2'b00}), fld(1));
      chk("oe", {28'h0, s[3:0] & ~{s[5:4], 2'b00}}, fld(0));
    end
    // Rising edge keypad lines turn their pull into a pulldown.
    req <= '0;
    req.kbi_en <= 4'hf;
    req.kbi_rise <= 4'h5;
    apb(1, ADDR_PULLUP, 32'h0f);
    repeat (3) @(posedge mclk);
    chk("pd", 32'h05, fld(2));
    chk("pu", 32'h1a, fld(1));
    chk("kbi", 32'ha, 32'(route.keypad_in));
    // Slew and drive on output lines.
    req <= '0;
    req.gpio_dir <= 6'h0f;
    s = 6'($urandom());
    pe = 6'($urandom());
    apb(1, ADDR_SLEW, {26'h0, s});
    apb(1, ADDR_DRIVE, {26'h0, pe});
    repeat (3) @(posedge mclk);
    chk("slew", {28'h0, s[3:0]}, fld(3) & 32'h0f);
    chk("hdrv", {28'h0, pe[3:0]}, 32'({pad_ctl[3].hdrv, pad_ctl[2].hdrv,
        pad_ctl[1].hdrv, pad_ctl[0].hdrv}));
    // Capture input follows line 5; both analog modules share a pin.
    req <= '0;
    req.t2_capture <= 1'b1;
    req.ana_a <= 4'h6;
    req.ana_b <= 4'h6;
    hold_en[5] <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      hold_val[5] <= v[0];
      repeat (4) @(posedge mclk);
      chk("cap", 32'(v[0]), 32'(route.t2_capture_in));
    end
    chk("ana", 32'h66, {24'h0, route.ana_a_sel, route.ana_b_sel});
    // Interrupt request outranks capture on line 5.
    req.irq_en <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("cap", 0, 32'(route.t2_capture_in));
    // Debug owns line 4 until its enable is cleared.
    req <= '0;
    hold_en[5] <= 1'b0;
    req.dbg_oe <= 1'b1;
    req.t2_oe <= 1'b1;
    req.t2_out <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("l4", 32'h2, {30'h0, pad_ctl[4].oe, pad_ctl[4].out});
    apb(1, ADDR_OPTION, 0);
    repeat (3) @(posedge mclk);
    chk("l4", 32'h6, {29'h0, pad_ctl[4].oe, pad_ctl[4].out,
        pad_ctl[4].pu});
    // Reset pin function, its pullup and its stickiness.
    req <= '0;
    apb(1, ADDR_OPTION, 32'h1);
    repeat (3) @(posedge mclk);
    chk("pu5", 1, 32'(pad_ctl[5].pu));
    hold_en[5] <= 1'b1;
    hold_val[5] <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("ext", 1, 32'(ext_rst));
    hold_val[5] <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("ext", 0, 32'(ext_rst));
    hold_en[5] <= 1'b0;
    do_reset(1'b0, 1'b1);
    chk("bg", 0, 32'(bg_mode));
    apb(0, ADDR_OPTION, 0);
    chk("opt", 32'h3, rd);
    // Forced debug reset with mode select low enters background.
    apb(1, ADDR_FORCE, 32'h1);
    seen = 1'b0;
    repeat (4) begin
      @(posedge mclk);
      seen = seen | (frc_rst === 1'b1);
    end
    chk("force", 1, 32'(seen));
    do_reset(1'b0, 1'b1);
    chk("bg", 1, 32'(bg_mode));
    do_reset(1'b1, 1'b0);
    chk("bg", 0, 32'(bg_mode));
    apb(0, ADDR_OPTION, 0);
    chk("opt", 32'h2, rd);
    do_reset(1'b1, 1'b1);
    chk("bg", 1, 32'(bg_mode));
    apb(0, ADDR_OPTION, 0);
    chk("opt", 32'h3, rd);
    apb(0, ADDR_STATUS, 0);
    chk("stat", 32'h7, rd);
    apb(0, 8'h18, 0);
    chk("err", 1, 32'(err));
    finish_test();
  end
endmodule
`default_nettype wire
